// >>> core/hpp_pkg.sv
// Purpose: constants for the host access port
// Assumes: core_clk at 40 MHz
// Notes: serial control word is 16 bits then 8 data bits
package hpp_pkg;
  localparam int HPP_DATA_W = 8;
  localparam int HPP_ADDR_W = 14;
  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int HPP_CTRL_BITS = 16;
  localparam int HPP_FRAME_BITS = 24;
  localparam int HPP_RW_POS = 15;
  localparam int HPP_B_POS = 0;
  localparam int HPP_ADDR_LSB = 1;
  // ----------------------------------------
  // pin positions on the shared bus
  // ----------------------------------------
  localparam int HPP_PIN_MISO = 0;
  localparam int HPP_PIN_MOSI = 1;
  localparam int HPP_PIN_SCLK = 2;
  localparam int HPP_PIN_SWAP = 5;
  localparam int HPP_PIN_CPHA = 6;
  localparam int HPP_PIN_CPOL = 7;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] HPP_DATA_RST = 8'h00;
  localparam logic [4:0] HPP_CNT_RST = 5'h00;
endpackage

// >>> core/hpp_sync.sv
// Purpose: two flip-flop synchroniser for a bus of pins
// Assumes: inputs asynchronous to core_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module hpp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1 = clk_en ? async_in : stage1;
    next_sync_out = clk_en ? stage1 : sync_out;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

// >>> core/hpp_port.sv
// Purpose: parallel or serial host register access port
// Assumes: register file outside, answers reg_rdata combinationally
// Notes: strobes and serial clock sampled by core_clk
//
// Overview of operation
// - data bus undriven while chip select high
// - strobes count only with chip select low
// - parallel read drives register while strobe, select low
// - bit 5 picks lsb or msb first
// - read/write and B bits stay fixed
// - bit 2 is serial clock input
// - bit 1 mosi in, bit 0 miso out
// - parallel write latched at write strobe rising edge
`timescale 1ns/1ps
module hpp_port
  import hpp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic serial_mode_sel,
  input wire logic bus_timing_select,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [HPP_ADDR_W-1:0] addr,
  input wire logic [HPP_DATA_W-1:0] data_in,
  output logic [HPP_DATA_W-1:0] data_out,
  output logic [HPP_DATA_W-1:0] data_oe,
  output logic [HPP_ADDR_W-1:0] reg_addr,
  output logic [HPP_DATA_W-1:0] reg_wdata,
  output logic reg_we,
  output logic reg_b,
  input wire logic [HPP_DATA_W-1:0] reg_rdata
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int SW = 3 + 1 + HPP_ADDR_W + HPP_DATA_W + 1;
  logic [SW-1:0] s_bus;
  logic cs_n, rd_n, wr_n, ser, wr_n_d;
  logic cs_act, rd_act, wr_act;
  logic [HPP_ADDR_W-1:0] s_addr;
  logic [HPP_DATA_W-1:0] s_data;

  hpp_sync #(.W(SW)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({~chip_select_n, ~read_strobe_n, ~write_strobe_n, serial_mode_sel, addr,
      data_in, bus_timing_select}),
    .sync_out(s_bus)
  );
  // active-low pins travel inverted so a reset synchroniser reads as idle
  assign {cs_act, rd_act, wr_act, ser, s_addr, s_data} = s_bus[SW-1:1];
  assign cs_n = ~cs_act;
  assign rd_n = ~rd_act;
  assign wr_n = ~wr_act;

  wire logic sclk = s_data[HPP_PIN_SCLK];
  wire logic mosi = s_data[HPP_PIN_MOSI];
  wire logic cpol = s_data[HPP_PIN_CPOL];
  wire logic cpha = s_data[HPP_PIN_CPHA];
  wire logic msb_first = s_data[HPP_PIN_SWAP];

  // ----------------------------------------
  // serial engine state
  // ----------------------------------------
  logic sclk_d, next_sclk_d;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [HPP_CTRL_BITS-1:0] ctrl_sr, next_ctrl_sr, ctrl_word;
  logic [HPP_DATA_W-1:0] dat_sr, next_dat_sr;
  logic [HPP_DATA_W-1:0] tx_sr, next_tx_sr;
  logic miso, next_miso;
  logic [HPP_DATA_W-1:0] next_data_out, next_data_oe, next_reg_wdata;
  logic [HPP_ADDR_W-1:0] next_reg_addr, ctl_addr, raw_addr;
  logic next_reg_we, next_reg_b, next_wr_n_d;
  logic lead, trail, smp, shf;

  // rearrange address bits by order; rw and B untouched
  always_comb begin
    // control word including the bit being sampled now
    ctrl_word = {ctrl_sr[HPP_CTRL_BITS-2:0], mosi};
    raw_addr = ctrl_word[HPP_ADDR_LSB +: HPP_ADDR_W];
    for (int i = 0; i < HPP_ADDR_W; i++) begin
      ctl_addr[i] = msb_first ? raw_addr[i] : raw_addr[HPP_ADDR_W-1-i];
    end
  end

  always_comb begin
    lead = (sclk != sclk_d) && (sclk != cpol);
    trail = (sclk != sclk_d) && (sclk == cpol);
    smp = cpha ? trail : lead;
    shf = cpha ? lead : trail;
    next_sclk_d = sclk;
    next_bit_cnt = bit_cnt;
    next_ctrl_sr = ctrl_sr;
    next_dat_sr = dat_sr;
    next_tx_sr = tx_sr;
    next_miso = miso;
    next_data_out = data_out;
    next_data_oe = '0;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_we = 1'b0;
    next_reg_b = reg_b;
    next_wr_n_d = wr_n;
    if (cs_n) begin
      next_bit_cnt = HPP_CNT_RST;
      next_data_out = HPP_DATA_RST;
    end else if (ser) begin
      // serial mode: only miso driven, strobes ignored
      next_data_oe[HPP_PIN_MISO] = 1'b1;
      next_data_out = {{(HPP_DATA_W-1){1'b0}}, miso};
      if (smp && bit_cnt < 5'(HPP_FRAME_BITS)) begin
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt < 5'(HPP_CTRL_BITS))
          next_ctrl_sr = ctrl_word;
        else if (msb_first)
          next_dat_sr = {dat_sr[HPP_DATA_W-2:0], mosi};
        else
          next_dat_sr = {mosi, dat_sr[HPP_DATA_W-1:1]};
        if (bit_cnt == 5'(HPP_CTRL_BITS - 1)) begin
          next_reg_addr = ctl_addr;
          next_reg_b = ctrl_word[HPP_B_POS];
        end
        if (bit_cnt == 5'(HPP_FRAME_BITS - 1) && !ctrl_sr[HPP_RW_POS]) begin
          next_reg_we = 1'b1;
          next_reg_wdata = msb_first ? {dat_sr[HPP_DATA_W-2:0], mosi}
                                     : {mosi, dat_sr[HPP_DATA_W-1:1]};
        end
      end
      if (shf && bit_cnt == 5'(HPP_CTRL_BITS)) begin
        next_miso = msb_first ? reg_rdata[HPP_DATA_W-1] : reg_rdata[0];
        next_tx_sr = msb_first ? {reg_rdata[HPP_DATA_W-2:0], 1'b0}
                               : {1'b0, reg_rdata[HPP_DATA_W-1:1]};
      end else if (shf && bit_cnt > 5'(HPP_CTRL_BITS)) begin
        next_miso = msb_first ? tx_sr[HPP_DATA_W-1] : tx_sr[0];
        next_tx_sr = msb_first ? {tx_sr[HPP_DATA_W-2:0], 1'b0} : {1'b0, tx_sr[HPP_DATA_W-1:1]};
      end
    end else begin
      next_reg_addr = s_addr;
      if (!rd_n) begin
        next_data_oe = '1;
        next_data_out = reg_rdata;
      end
      if (wr_n && !wr_n_d) begin
        next_reg_we = 1'b1;
        next_reg_wdata = s_data;
      end
    end
    if (ser && cs_n) next_miso = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d <= 1'b0;
      bit_cnt <= HPP_CNT_RST;
      ctrl_sr <= '0;
      dat_sr <= '0;
      tx_sr <= '0;
      miso <= 1'b0;
      data_out <= HPP_DATA_RST;
      data_oe <= '0;
      reg_addr <= '0;
      reg_wdata <= HPP_DATA_RST;
      reg_we <= 1'b0;
      reg_b <= 1'b0;
      wr_n_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d <= next_sclk_d;
      bit_cnt <= next_bit_cnt;
      ctrl_sr <= next_ctrl_sr;
      dat_sr <= next_dat_sr;
      tx_sr <= next_tx_sr;
      miso <= next_miso;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_we <= next_reg_we;
      reg_b <= next_reg_b;
      wr_n_d <= next_wr_n_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  bus_float_cs_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && cs_n |=> data_oe == '0)
    else $error("data bus driven while deselected");
  strobe_qual_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && cs_n && !ser |=> !reg_we)
    else $error("write taken while deselected");
  read_drive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !cs_n && !rd_n && !ser |=> data_oe == '1 && data_out == $past(reg_rdata))
    else $error("read data not driven");
  order_msb_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && ser && !cs_n && shf && bit_cnt == 5'(HPP_CTRL_BITS) && msb_first
    |=> miso == $past(reg_rdata[HPP_DATA_W-1]))
    else $error("msb first not honoured");
  rw_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && ser && !cs_n && smp && bit_cnt == 5'(HPP_FRAME_BITS - 1) && ctrl_sr[HPP_RW_POS]
    |=> !reg_we)
    else $error("read frame caused a write");
  serial_oe_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && ser && !cs_n |=> data_oe == 8'h01)
    else $error("serial mode drives wrong pins");
  write_edge_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !cs_n && !ser && wr_n && !wr_n_d |=> reg_we && reg_wdata == $past(s_data))
    else $error("write edge missed");
  serial_nopar_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && ser && !cs_n && !smp |=> !reg_we)
    else $error("parallel write in serial mode");
endmodule

// >>> verification/hpp_host.sv
// Purpose: host processor model for the shared pins
// Assumes: pins change on core_clk edges
// Notes: serial clock idles at the polarity strap
`timescale 1ns/1ps
module hpp_host
  import hpp_pkg::*;
(
  input wire logic core_clk,
  input wire logic [HPP_DATA_W-1:0] data_out,
  input wire logic [HPP_DATA_W-1:0] data_oe,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic serial_mode_sel,
  output logic [HPP_ADDR_W-1:0] addr,
  output logic [HPP_DATA_W-1:0] hd
);
  initial begin
    {chip_select_n, read_strobe_n, write_strobe_n, serial_mode_sel} = 4'hE;
    addr = 14'h0000;
    hd = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // parallel cycle, read strobe held until the port drives or 8 cycles pass
  task automatic par(input logic ser, input logic wr, input logic cs, input logic [13:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic [7:0] qoe);
    serial_mode_sel <= ser;
    addr <= a;
    hd <= d;
    chip_select_n <= cs;
    idle(4);
    if (wr) begin
      write_strobe_n <= 1'b0;
      idle(3);
      write_strobe_n <= 1'b1;
    end else begin
      read_strobe_n <= 1'b0;
      hd <= ~d;
      for (int i = 0; i < 8; i++) begin
        idle(1);
        if (data_oe === 8'hFF) break;
      end
    end
    q = data_out;
    qoe = data_oe;
    read_strobe_n <= 1'b1;
    idle(4);
    chip_select_n <= 1'b1;
    idle(4);
    serial_mode_sel <= 1'b0;
    idle(1);
  endtask
  // serial frame in any clock mode, md is {polarity, phase}
  task automatic spi(input logic [1:0] md, input logic sw, input logic rw, input logic [13:0] a,
                     input logic b, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f[23] = rw;
    f[8] = b;
    for (int i = 0; i < 14; i++) f[22 - i] = sw ? a[13 - i] : a[i];
    for (int i = 0; i < 8; i++) f[7 - i] = sw ? d[7 - i] : d[i];
    serial_mode_sel <= 1'b1;
    hd <= {md, sw, 2'b00, md[1], 2'b00};
    idle(4);
    chip_select_n <= 1'b0;
    idle(4);
    for (int i = 23; i >= 0; i--) begin
      // first edge of the bit, data changes with it
      hd <= {md, sw, 2'b00, md[0] ^ md[1], f[i], 1'b0};
      idle(4);
      hd[HPP_PIN_SCLK] <= ~(md[0] ^ md[1]);
      idle(4);
      q = {q[6:0], data_out[HPP_PIN_MISO]};
    end
    hd <= {md, sw, 2'b00, md[1], ~f[0], 1'b0};
    idle(4);
    chip_select_n <= 1'b1;
    idle(4);
    serial_mode_sel <= 1'b0;
    idle(1);
    if (!sw) q = {<<{q}};
  endtask
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the host port
// Assumes: small register file modelled here
// Notes: serial clock period 200 ns
`timescale 1ns/1ps
module testbench
  import hpp_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_n, rd_n, wr_n, ser, reg_we, reg_b, last_b;
  logic [HPP_ADDR_W-1:0] addr, reg_addr, last_a;
  logic [HPP_DATA_W-1:0] hd, pins, data_out, data_oe, reg_wdata, reg_rdata, q, qoe;
  logic [7:0] mem [16];
  int we_cnt = 0;
  int miscompares = 0;
  int samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  assign pins = (data_oe & data_out) | (~data_oe & hd);
  assign reg_rdata = mem[reg_addr[3:0]];
  always @(posedge core_clk) begin
    if (reg_we === 1'b1) begin
      mem[reg_addr[3:0]] <= reg_wdata;
      {last_b, last_a} <= {reg_b, reg_addr};
      we_cnt <= we_cnt + 1;
    end
  end
  hpp_host host (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .serial_mode_sel(ser), .addr(addr), .hd(hd));
  hpp_port DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .serial_mode_sel(ser),
    .bus_timing_select(1'b0), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr(addr), .data_in(pins), .data_out(data_out),
    .data_oe(data_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_b(reg_b), .reg_rdata(reg_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    host.idle(4);
    host.par(1'b0, 1'b1, 1'b0, 14'h0003, 8'hA5, q, qoe);
    host.par(1'b0, 1'b1, 1'b0, 14'h000C, 8'h3C, q, qoe);
    check({2'h0, last_a}, 16'h000C);
    host.par(1'b0, 1'b0, 1'b0, 14'h0003, 8'h00, q, qoe);
    check({qoe, q}, 16'hFFA5);
    $display("test parallel done");
    host.par(1'b0, 1'b1, 1'b1, 14'h0003, 8'h11, q, qoe);
    host.par(1'b0, 1'b0, 1'b1, 14'h000C, 8'h00, q, qoe);
    check({8'h00, qoe}, 16'h0000);
    host.par(1'b1, 1'b1, 1'b0, 14'h0003, 8'h00, q, qoe);
    check(we_cnt[15:0], 16'h0002);
    host.par(1'b1, 1'b0, 1'b0, 14'h000C, 8'hE4, q, qoe);
    check({9'h000, qoe[7:1]}, 16'h0000);
    $display("test refusal done");
    host.spi(2'h0, 1'b1, 1'b0, 14'h0005, 1'b1, 8'hC3, q);
    check({1'b0, last_b, last_a}, 16'h4005);
    check({8'h00, mem[5]}, 16'h00C3);
    host.spi(2'h3, 1'b0, 1'b0, 14'h0009, 1'b0, 8'h96, q);
    check({1'b0, last_b, last_a}, 16'h0009);
    check({8'h00, mem[9]}, 16'h0096);
    host.spi(2'h1, 1'b1, 1'b1, 14'h0005, 1'b0, 8'h00, q);
    check({8'h00, q}, 16'h00C3);
    host.spi(2'h2, 1'b0, 1'b1, 14'h0009, 1'b1, 8'h00, q);
    check({8'h00, q}, 16'h0096);
    check(we_cnt[15:0], 16'h0004);
    $display("test serial done");
    report_and_stop();
  end
endmodule
